/* rtl/led_pwm_pkg.sv */
/*
 * Shared constants and types for the sixteen-channel serial-loaded LED PWM sink.
 * Assumes a single 125 MHz system clock; every external level is synchronised before use.
 */
package led_pwm_pkg;
   // channel geometry
   localparam int unsigned NUM_CH = 16;
   localparam int unsigned GS_W = 12;
   localparam int unsigned TRIM_W = 6;
   localparam int unsigned GS_FRAME = 192;
   localparam int unsigned TRIM_FRAME = 96;

   // timing
   localparam int unsigned CLK_PERIOD_PS = 8000;
   localparam int unsigned STAGGER_PS = 20000;
   localparam int unsigned STAGGER_CYC = (STAGGER_PS / CLK_PERIOD_PS) < 1 ? 1 : (STAGGER_PS / CLK_PERIOD_PS);

   // register byte offsets
   localparam logic [11:0] STATUS_OFS = 12'h000;
   localparam logic [11:0] COUNT_OFS = 12'h004;
   localparam logic [11:0] CTRL_OFS = 12'h008;
   localparam logic [11:0] CAPT_OFS = 12'h00c;

   // field positions in the status and control words
   localparam int unsigned ST_OVERTEMP_BIT = 16;
   localparam int unsigned ST_DISABLE_BIT = 17;
   localparam int unsigned ST_PROGSEL_BIT = 18;
   localparam int unsigned ST_TRIMSRC_BIT = 19;
   localparam int unsigned CTRL_PROG_BIT = 0;

   // reset values
   localparam logic [GS_W-1:0] GS_RESET = 12'h000;
   localparam logic [TRIM_W-1:0] TRIM_RESET = 6'h3f;
   localparam logic [TRIM_W-1:0] EEPROM_RESET = 6'h3f;

   // error sources travelling together
   typedef struct packed {
      logic overtemp_flag;
      logic [NUM_CH-1:0] open_led_flag;
   } err_flags_t;
endpackage

/* rtl/led_pwm_serial_loader.sv */
/*
 * Sixteen-channel grayscale PWM sink driver loaded over a three-wire shift link.
 * Assumes shift clock, latch, grayscale clock and sense inputs are asynchronous pins
 * sampled by pclk; the shift clock runs well below pclk/4 so every edge is seen.
 */
`timescale 1ns/1ps
`default_nettype none

// How it works
// R01 - each rising shift clock edge shifts serial_in into the input register
// R02 - a high latch pulse after a full frame moves the frame inside
// R03 - inner registers follow the shift register throughout the latch-high level
// R04 - frames travel most significant bit first
// R05 - frame is 96 bits in trim mode and 192 in grayscale mode
// R06 - shifting during a PWM cycle leaves outputs alone until the latch
// R07 - host should latch new grayscale data at a cycle end only
// R08 - latched grayscale replaces the active value at once
// R09 - the bit leaving the shift register appears on serial_out
// R10 - status shifts out on serial_out while new data shifts in
// R11 - only serial_in, shift clock and latch pulse load data
// R12 - sixteen sink channels, each with own grayscale and trim
// R13 - 12-bit grayscale gives 4096 on-time steps per channel
// R14 - 6-bit trim gives 64 current steps per channel
// R15 - program_select decides which register set the latch updates
// R16 - a nonvolatile trim copy can replace the volatile trim register
// R17 - on-time equals grayscale value times grayscale clock period
// R18 - each channel switches about 20 ns after the one below; here 16 ns, two pclk cycles
// R19 - open-LED flag rises when a driven channel senses an open LED
// R20 - over-temperature flag rises when the die is too hot
// R21 - output_disable turns all channels off and clears the counter
// R22 - program_select and trim_source_select choose mode and trim source
// R23 - open-LED bits are captured into status on latch falling edge
// R24 - error output pulled low while any error flag is active
// R25 - counter advances per grayscale clock; channel on while counter below value
// R26 - shift and grayscale clock domains are asynchronous and crossed safely
module led_pwm_serial_loader #(
   parameter int unsigned NUM_CH = led_pwm_pkg::NUM_CH,
   parameter int unsigned GS_W = led_pwm_pkg::GS_W,
   parameter int unsigned TRIM_W = led_pwm_pkg::TRIM_W
) (
   // system
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial link
   input wire logic shift_clk,
   input wire logic serial_in,
   input wire logic latch_pulse,
   output logic serial_out,
   // mode and pwm control pins
   input wire logic program_select,
   input wire logic trim_source_select,
   input wire logic output_disable,
   input wire logic gs_clk,
   // analog sense pins
   input wire logic [NUM_CH-1:0] open_led_sense,
   input wire logic overtemp_sense,
   // sink channels and their current trim
   output logic [NUM_CH-1:0] sink_channel,
   output logic [NUM_CH*TRIM_W-1:0] current_trim,
   // open-drain error pin
   output logic error_out_n_out,
   output logic error_out_n_oe
);

   // derived sizes: frame widths, pin count and the stagger chain length
   localparam int unsigned GS_BITS = NUM_CH * GS_W;
   localparam int unsigned TR_BITS = NUM_CH * TRIM_W;
   localparam int unsigned NSYNC = NUM_CH + 8;
   localparam int unsigned STG = led_pwm_pkg::STAGGER_CYC;
   localparam int unsigned DLY_W = (NUM_CH - 1) * STG + 1;

   // synchroniser stages; first stage only feeds the second
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] meta_ff;
   logic [NSYNC-1:0] sync_ff;
   logic [NSYNC-1:0] prev_ff;

   // every pin passes two flops; only three of them load data [R11]
   assign raw_in = {open_led_sense, overtemp_sense, gs_clk, output_disable, trim_source_select,
                    program_select, latch_pulse, serial_in, shift_clk};

   // two-flop synchroniser on every asynchronous pin [R26]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= raw_in;
         sync_ff <= meta_ff;
      end
   end

   // settled levels one cycle late, so edges are found on clean values only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_ff <= '0;
      end else begin
         prev_ff <= sync_ff;
      end
   end

   // named views of the synchronised levels
   wire sclk_s = sync_ff[0];
   wire sin_s = sync_ff[1];
   wire lat_s = sync_ff[2];
   wire prog_s = sync_ff[3];
   wire tsrc_s = sync_ff[4];
   wire dis_s = sync_ff[5];
   wire gclk_s = sync_ff[6];
   wire otemp_s = sync_ff[7];
   wire [NUM_CH-1:0] sense_s = sync_ff[NSYNC-1:8];

   // edges found on the sampled link and grayscale clocks
   wire sclk_rise = sclk_s & ~prev_ff[0];
   wire lat_fall = ~lat_s & prev_ff[2];
   wire gclk_rise = gclk_s & ~prev_ff[6];

   // input shift register and inner register sets
   logic [GS_BITS-1:0] shift_ff;
   logic [GS_BITS-1:0] nxt_shift;
   logic [GS_BITS-1:0] gs_ff;
   logic [TR_BITS-1:0] trim_ff;
   logic [TR_BITS-1:0] eeprom_ff;
   logic [TR_BITS-1:0] nxt_eeprom;
   logic [GS_W-1:0] count_ff;
   logic [GS_W-1:0] nxt_count;
   led_pwm_pkg::err_flags_t flags_ff;
   led_pwm_pkg::err_flags_t nxt_flags;
   logic [NUM_CH-1:0] capt_ff;
   logic err_oe_ff;

   // status word loaded into the top of the shift register at latch fall
   // takes the flags captured at that same edge, not the previous capture [R23]
   wire [GS_BITS-1:0] status_frame = {flags_ff.open_led_flag, flags_ff.overtemp_flag,
                                      {(GS_BITS - NUM_CH - 1){1'b0}}};
   // frame top: bit 191 in grayscale mode, bit 95 in trim mode [R05] [R22]
   wire frame_msb = prog_s ? shift_ff[led_pwm_pkg::TRIM_FRAME-1] : shift_ff[GS_BITS-1];
   // trim-mode status sits in the low 96 bits' window, its top bit at the bit 95 frame top
   wire [GS_BITS-1:0] status_load = prog_s ? (status_frame >> (GS_BITS - led_pwm_pkg::TRIM_FRAME)) : status_frame;

   // shift left so the first bit in ends up most significant [R01] [R04]
   always_comb begin
      nxt_shift = shift_ff;
      if (sclk_rise) begin
         nxt_shift = {shift_ff[GS_BITS-2:0], sin_s}; // [R01]
      end else if (lat_fall) begin
         nxt_shift = status_load; // [R10] [R23]
      end
   end

   // bit leaving the register drives the cascade / readback output [R09] [R10]
   assign serial_out = frame_msb;

   // shift register state; cleared so serial_out idles low after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_ff <= '0;
      end else begin
         shift_ff <= nxt_shift;
      end
   end

   // program select picks which inner set follows the shift register while the latch is high [R15] [R22]
   wire load_gs = lat_s & ~prog_s;
   wire load_trim = lat_s & prog_s;

   // grayscale set is transparent while the latch level is high [R02] [R03]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gs_ff <= {NUM_CH{led_pwm_pkg::GS_RESET}};
      end else if (load_gs) begin
         gs_ff <= shift_ff; // immediate overwrite mid-cycle [R08] [R06]
      end
   end

   // trim set, equally transparent in trim entry mode [R03]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trim_ff <= {NUM_CH{led_pwm_pkg::TRIM_RESET}};
      end else if (load_trim) begin
         trim_ff <= shift_ff[TR_BITS-1:0]; // [R05] [R14]
      end
   end

   // nonvolatile trim copy, programmed from the trim register by software [R16]
   logic prog_req;
   always_comb begin
      nxt_eeprom = eeprom_ff;
      if (prog_req) begin
         nxt_eeprom = trim_ff;
      end
   end

   // stored trim copy; changes only on a software program request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eeprom_ff <= {NUM_CH{led_pwm_pkg::EEPROM_RESET}};
      end else begin
         eeprom_ff <= nxt_eeprom;
      end
   end

   // trim source: low picks the stored copy, high the trim register [R16] [R22]
   wire [TR_BITS-1:0] trim_sel = tsrc_s ? trim_ff : eeprom_ff;
   // registered so the trim outputs never glitch while the source select moves
   logic [TR_BITS-1:0] trim_out_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trim_out_ff <= {NUM_CH{led_pwm_pkg::TRIM_RESET}};
      end else begin
         trim_out_ff <= trim_sel; // [R14]
      end
   end
   assign current_trim = trim_out_ff;

   // grayscale counter: advances per gs clock, cleared while disabled [R21] [R25]
   always_comb begin
      nxt_count = count_ff;
      if (dis_s) begin
         nxt_count = '0; // [R21]
      end else if (gclk_rise) begin
         nxt_count = count_ff + 1'b1; // wraps after 4096 steps [R13] [R25]
      end
   end

   // counter state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_ff <= '0;
      end else begin
         count_ff <= nxt_count;
      end
   end

   // per-channel compare, then staggered delay chain toward the pins
   logic [NUM_CH-1:0] pwm_raw;
   logic [NUM_CH-1:0] sink_ff;
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         logic [DLY_W-1:0] dly_ff;
         logic sink_q;
         // on while counter below value: value n gives n gs periods [R12] [R13] [R17] [R25]
         assign pwm_raw[ch] = ~dis_s & (count_ff < gs_ff[ch*GS_W +: GS_W]);

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               dly_ff <= '0;
            end else begin
               dly_ff <= {dly_ff[DLY_W-2:0], pwm_raw[ch]};
            end
         end

         // channel n waits n stagger steps, on both edges; disable acts at once [R18] [R21]
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sink_q <= 1'b0;
            end else begin
               sink_q <= ~dis_s & dly_ff[ch*STG];
            end
         end
         // each channel's flop owns its bit of the sink vector
         assign sink_ff[ch] = sink_q;
      end
   endgenerate
   assign sink_channel = sink_ff;

   // error flags: open led on a driven channel, die over temperature [R19] [R20]
   always_comb begin
      nxt_flags.open_led_flag = sink_ff & sense_s; // [R19]
      nxt_flags.overtemp_flag = otemp_s; // [R20]
   end

   // flag state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_ff <= '0;
      end else begin
         flags_ff <= nxt_flags;
      end
   end

   // open-led bits frozen for readback at each latch fall [R23]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capt_ff <= '0;
      end else if (lat_fall) begin
         capt_ff <= flags_ff.open_led_flag; // [R23]
      end
   end

   // pin follows the fresh flags so it lags them by no extra cycle [R24]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_oe_ff <= 1'b0;
      end else begin
         err_oe_ff <= nxt_flags.overtemp_flag | (|nxt_flags.open_led_flag); // [R24]
      end
   end

   // open-drain pin: drives low only while an error is present [R24]
   assign error_out_n_out = 1'b0;
   assign error_out_n_oe = err_oe_ff;

   // apb decode; zero-wait answers, unmapped access flagged
   wire acc = psel & penable;
   wire hit_status = (paddr == led_pwm_pkg::STATUS_OFS);
   wire hit_count = (paddr == led_pwm_pkg::COUNT_OFS);
   wire hit_ctrl = (paddr == led_pwm_pkg::CTRL_OFS);
   wire hit_capt = (paddr == led_pwm_pkg::CAPT_OFS);
   wire hit_any = hit_status | hit_count | hit_ctrl | hit_capt;
   assign prog_req = acc & pwrite & hit_ctrl & pwdata[led_pwm_pkg::CTRL_PROG_BIT];

   // status word assembly
   logic [31:0] status_word;
   always_comb begin
      status_word = '0;
      status_word[NUM_CH-1:0] = flags_ff.open_led_flag;
      status_word[led_pwm_pkg::ST_OVERTEMP_BIT] = flags_ff.overtemp_flag;
      status_word[led_pwm_pkg::ST_DISABLE_BIT] = dis_s;
      status_word[led_pwm_pkg::ST_PROGSEL_BIT] = prog_s;
      status_word[led_pwm_pkg::ST_TRIMSRC_BIT] = tsrc_s;
   end

   // read data mux; registers below read as zero outside their fields
   wire [31:0] rd_mux = hit_status ? status_word :
                        hit_count ? {{(32 - GS_W){1'b0}}, count_ff} :
                        hit_capt ? {{(32 - NUM_CH){1'b0}}, capt_ff} : 32'h0000_0000;

   // zero wait states; error flagged only for unmapped addresses
   assign pready = 1'b1;
   assign pslverr = acc & ~hit_any;
   assign prdata = (acc & ~pwrite) ? rd_mux : 32'h0000_0000;

endmodule
`default_nettype wire

/* verif/led_pwm_sva.sv */
/* assertions on the sink, error pin, serial output and apb ports of the led pwm loader.
   assumes pclk clocks every port and presetn resets them asynchronously. */
`timescale 1ns/1ps
`default_nettype none
module led_pwm_sva #(
   parameter int unsigned NUM_CH = 16
) (
   // system
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // link and pins
   input wire logic shift_clk,
   input wire logic latch_pulse,
   input wire logic program_select,
   input wire logic serial_out,
   input wire logic output_disable,
   input wire logic [NUM_CH-1:0] open_led_sense,
   input wire logic overtemp_sense,
   input wire logic [NUM_CH-1:0] sink_channel,
   input wire logic error_out_n_out,
   input wire logic error_out_n_oe
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // sinks, error pin and serial output
   property p_disable_off; output_disable [*5] |-> sink_channel == '0; endproperty
   a_disable_off: assert property (p_disable_off) else $error("sinks on while disabled");
   property p_err_set; overtemp_sense [*6] |-> error_out_n_oe; endproperty
   a_err_set: assert property (p_err_set) else $error("error pin not pulled");
   property p_err_clr; (!overtemp_sense && open_led_sense == '0) [*8] |-> !error_out_n_oe; endproperty
   a_err_clr: assert property (p_err_clr) else $error("error pin not released");
   property p_err_drive; error_out_n_oe |-> !error_out_n_out; endproperty
   a_err_drive: assert property (p_err_drive) else $error("error pin driven high");
   property p_serial_out_hold;
      ($stable(shift_clk) && $stable(latch_pulse) && $stable(program_select)) [*6] |=> $stable(serial_out);
   endproperty
   a_serial_out_hold: assert property (p_serial_out_hold) else $error("serial out moved without shift");

   // apb answers
   property p_apb_ready; psel && penable |-> pready; endproperty
   a_apb_ready: assert property (p_apb_ready) else $error("no ready in access");
   property p_rd_idle; !(psel && penable) |-> prdata == '0 && !pslverr; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("apb outputs not idle");
   property p_unmapped; psel && penable && paddr > 12'h00c |-> pslverr && prdata == '0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
endmodule
bind led_pwm_serial_loader led_pwm_sva #(.NUM_CH(NUM_CH)) u_led_pwm_sva (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .shift_clk(shift_clk), .latch_pulse(latch_pulse), .program_select(program_select),
   .serial_out(serial_out), .output_disable(output_disable), .open_led_sense(open_led_sense),
   .overtemp_sense(overtemp_sense), .sink_channel(sink_channel), .error_out_n_out(error_out_n_out),
   .error_out_n_oe(error_out_n_oe));
`default_nettype wire

/* verif/link_host.sv */
/* host model of the three-wire link: shifts frames msb first and pulses the latch.
   assumes the bench calls its tasks right after a pclk rising edge. */
`timescale 1ns/1ps
`default_nettype none
module link_host (
   // clock
   input wire logic pclk,
   // the three link pins that load data
   output logic shift_clk,
   output logic serial_in,
   output logic latch_pulse
);
   // shift clock stands low between frames
   initial begin
      shift_clk = 1'h0;
      serial_in = 1'h0;
      latch_pulse = 1'h0;
   end
   // one bit per 160 ns period; idle data shows the inverse of the last bit
   task automatic send(input logic [191:0] f, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         serial_in <= f[i];
         repeat (10) @(posedge pclk);
         shift_clk <= 1'h1;
         repeat (10) @(posedge pclk);
         shift_clk <= 1'h0;
      end
      serial_in <= ~f[0];
   endtask
   // high pulse after the frame moves it inside
   task automatic pulse_latch();
      latch_pulse <= 1'h1;
      repeat (6) @(posedge pclk);
      latch_pulse <= 1'h0;
      repeat (40) @(posedge pclk);
   endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
/* self-checking bench for the led pwm loader: apb table, trim and grayscale loads, errors.
   assumes the link host model drives the serial pins. */
`timescale 1ns/1ps
`default_nettype none
module tb;
   typedef struct packed {logic wr; logic [11:0] a; logic [31:0] d; logic e;} row_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic shift_clk, serial_in, latch_pulse, serial_out, program_select, trim_source_select;
   logic output_disable, gs_clk, overtemp_sense, error_out_n_out, error_out_n_oe;
   logic [15:0] open_led_sense, sink_channel;
   logic [95:0] current_trim;
   logic [191:0] f;
   wire err_line = error_out_n_oe ? error_out_n_out : 1'h1;
   int error_cnt = 0;
   int comparisons = 0;
   row_t rows [5] = '{'{1'h0, 12'h000, 32'h000a_0000, 1'h0}, '{1'h0, 12'h004, 32'h0, 1'h0},
      '{1'h0, 12'h008, 32'h0, 1'h0}, '{1'h0, 12'h00c, 32'h0, 1'h0}, '{1'h1, 12'h010, 32'h0, 1'h1}};

   led_pwm_serial_loader u_led_pwm_serial_loader (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .shift_clk(shift_clk), .serial_in(serial_in), .latch_pulse(latch_pulse),
      .serial_out(serial_out), .program_select(program_select), .trim_source_select(trim_source_select),
      .output_disable(output_disable), .gs_clk(gs_clk), .open_led_sense(open_led_sense),
      .overtemp_sense(overtemp_sense), .sink_channel(sink_channel), .current_trim(current_trim),
      .error_out_n_out(error_out_n_out), .error_out_n_oe(error_out_n_oe));
   link_host u_link_host (.pclk(pclk), .shift_clk(shift_clk), .serial_in(serial_in), .latch_pulse(latch_pulse));

   // clock and watchdog
   initial pclk = 1'h0;
   always #4 pclk = ~pclk;
   initial begin
      #400000;
      error_cnt++;
      test_done();
   end

   task automatic test_done();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [95:0] s, input logic [95:0] x);
      comparisons++;
      if (s !== x) begin
         error_cnt++;
         $display("BAD %s exp %h seen %h", nm, x, s);
      end
   endtask
   // apb transfer, entered right after a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) begin
         n++;
         if (n > 50) error_cnt++;
         if (n > 50) break;
         @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask
   task automatic gs_tick();
      gs_clk <= 1'h1;
      repeat (6) @(posedge pclk);
      gs_clk <= 1'h0;
      repeat (40) @(posedge pclk);
   endtask

   // main sequence
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, program_select, gs_clk} = '0;
      {overtemp_sense, open_led_sense} = '0;
      output_disable = 1'h1;
      trim_source_select = 1'h1;
      repeat (20) @(posedge pclk);
      chk("trim_rst", current_trim, {16{6'h3f}});
      chk("sink_rst", sink_channel, 16'h0);
      presetn <= 1'h1;
      repeat (8) @(posedge pclk);
      foreach (rows[i]) begin
         apb(rows[i].wr, rows[i].a, 32'h0);
         if (!rows[i].wr) chk("rdata", q, rows[i].d);
         chk("slverr", e, rows[i].e);
      end
      program_select <= 1'h1;
      f = '0;
      for (int c = 0; c < 16; c++) f[6*c +: 6] = 6'(c);
      u_link_host.send(f, 96);
      u_link_host.pulse_latch();
      chk("trim", current_trim, f[95:0]);
      trim_source_select <= 1'h0;
      repeat (8) @(posedge pclk);
      chk("trim_stored", current_trim, {16{6'h3f}});
      apb(1'h1, 12'h008, 32'h1);
      repeat (8) @(posedge pclk);
      chk("trim_copy", current_trim, f[95:0]);
      program_select <= 1'h0;
      output_disable <= 1'h0;
      f = '0;
      f[11:0] = 12'h001;
      f[191:180] = 12'h002;
      u_link_host.send(f, 192);
      u_link_host.pulse_latch();
      chk("sink_c0", sink_channel, 16'h8001);
      gs_tick();
      chk("sink_c1", sink_channel, 16'h8000);
      gs_tick();
      chk("sink_c2", sink_channel, 16'h0);
      apb(1'h0, 12'h004, 32'h0);
      chk("count", q, 32'h2);
      u_link_host.send({16{12'hfff}}, 192);
      chk("sink_hold", sink_channel, 16'h0);
      u_link_host.pulse_latch();
      chk("sink_new", sink_channel, 16'hffff);
      open_led_sense <= 16'h8000;
      program_select <= 1'h1;
      repeat (10) @(posedge pclk);
      chk("err_led", err_line, 1'h0);
      u_link_host.pulse_latch();
      apb(1'h0, 12'h00c, 32'h0);
      chk("capt", q, 32'h8000);
      chk("serial_out_top", serial_out, 1'h1);
      u_link_host.send(192'h0, 1);
      repeat (8) @(posedge pclk);
      chk("serial_out_next", serial_out, 1'h0);
      open_led_sense <= 16'h0;
      overtemp_sense <= 1'h1;
      repeat (10) @(posedge pclk);
      chk("err_hot", err_line, 1'h0);
      overtemp_sense <= 1'h0;
      output_disable <= 1'h1;
      repeat (10) @(posedge pclk);
      chk("err_clr", err_line, 1'h1);
      chk("sink_off", sink_channel, 16'h0);
      apb(1'h0, 12'h004, 32'h0);
      chk("count_clr", q, 32'h0);
      // mid-run reset: outputs and the captured status return to reset values
      presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      chk("serial_out_rst", serial_out, 1'h0);
      chk("trim_mid_rst", current_trim, {16{6'h3f}});
      presetn <= 1'h1;
      repeat (8) @(posedge pclk);
      apb(1'h0, 12'h00c, 32'h0);
      chk("capt_rst", q, 32'h0);
      test_done();
   end
endmodule
`default_nettype wire
